// ==== verilog/cao_top.sv ====
/*
 Channel alarm and relay output control: per channel filter, scaling,
 range check and two hysteresis alarms; per output combine, delays, holds.
 Assumes loop currents are 12-bit values in 0.01 mA units, synchronous to
 clk_i, refreshed with a one-cycle sample_i pulse.
*/
// How it works
// - Channel type is off, 0-20 mA or 4-20 mA; display derives from scaling.
// - Top current maps to full scale reading, bottom current to zero scale.
// - Zero scale above full scale gives a display falling with current.
// - Fraction digits setting selects zero to three decimals, passed to display.
// - Filter level 0 is none, up to 5 with the longest time constant.
// - Within margins show a value; beyond them raise over or under indication.
// - Under margin is 0.01 mA steps below 4 mA, only in 4-20 mA mode.
// - Over margin counts above 20 mA, 0 to 2.55 mA.
// - Every channel has two independent alarms feeding output control.
// - Over kind alarms above threshold, under kind alarms below it.
// - Thresholds are not checked; out of range means never or always.
// - With hysteresis an alarm sets only past threshold plus or minus it.
// - Over alarm clears at threshold minus hysteresis, under at plus.
// - Inactive output stays open and ignores all channel alarms.
// - Each output closes on active or opens on active.
// - Relay follows combined function directly or inverted by polarity.
// - Combine rule ORs or ANDs the attached channels.
// - Per channel source: none, alarm 1, alarm 2, either, both.
// - Inactive to active waits for the close delay, in either polarity.
// - Active to inactive waits for the open delay, in either polarity.
// - Frequent conditions with duty above half still switch eventually.
// - After each change the new state holds for its hold time.
// - During hold, alarms are ignored and delay counters frozen.
// - Delays and holds are 0 to 999 seconds in one-second steps.
// - Timed intervals may run slightly short of the setting.
`include "cao_params.svh"
module cao_top #(
  parameter int          N           = 4,
  parameter int          M           = 2,
  parameter int unsigned TICK_CYCLES = `CAO_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  // Loop currents, 0.01 mA each
  input  wire logic [12*N-1:0]           loop_current_i,
  input  wire logic                      sample_i,
  // Channel configuration
  input  wire logic [2*N-1:0]            input_type_i,
  input  wire logic [16*N-1:0]           full_scale_reading_i,
  input  wire logic [16*N-1:0]           zero_scale_reading_i,
  input  wire logic [2*N-1:0]            fraction_digits_i,
  input  wire logic [3*N-1:0]            filter_level_i,
  input  wire logic [8*N-1:0]            overrange_margin_i,
  input  wire logic [9*N-1:0]            underrange_margin_i,
  // Alarm configuration
  input  wire logic [N-1:0]              first_alarm_kind_i,
  input  wire logic [N-1:0]              second_alarm_kind_i,
  input  wire logic [16*N-1:0]           threshold1_i,
  input  wire logic [16*N-1:0]           threshold2_i,
  input  wire logic [16*N-1:0]           hysteresis1_i,
  input  wire logic [16*N-1:0]           hysteresis2_i,
  // Output configuration
  input  wire logic [2*M-1:0]            out_mode_i,
  input  wire logic [M-1:0]              channel_combine_rule_i,
  input  wire logic [3*N*M-1:0]          out_source_i,
  input  wire logic [`CAO_TIME_W*M-1:0]  close_delay_i,
  input  wire logic [`CAO_TIME_W*M-1:0]  open_delay_i,
  input  wire logic [`CAO_TIME_W*M-1:0]  closed_hold_i,
  input  wire logic [`CAO_TIME_W*M-1:0]  open_hold_i,
  // Channel results
  output logic [16*N-1:0]                display_value_o,
  output logic [2*N-1:0]                 fraction_digits_o,
  output logic [N-1:0]                   overrange_indication_o,
  output logic [N-1:0]                   underrange_indication_o,
  output logic [N-1:0]                   alarm1_o,
  output logic [N-1:0]                   alarm2_o,
  // Relays, high while closed
  output logic [M-1:0]                   relay_closed_o
);
  localparam int ACC_W = 12 + `CAO_FILT_FRAC;

  if (N < 1 || N > 16 || M < 1) begin : g_chk
    $error("cao_top: N must be 1..16 and M at least 1");
  end

  // Filter accumulators keep fraction bits so slow levels do not stall
  logic [ACC_W-1:0] acc_reg [N];
  logic [ACC_W-1:0] acc_next [N];
  logic [16*N-1:0]  val_reg, val_next;
  logic [2*N-1:0]   frac_reg, frac_next;
  logic [N-1:0]     over_reg, over_next, under_reg, under_next;
  logic [N-1:0]     al1_reg, al1_next, al2_reg, al2_next;
  wire  [M-1:0]     relay_w;

  cao_link_if #(.N(N)) lnk ();

  // Linear map of current onto the reading span; swapped ends invert it
  function automatic logic [15:0] scale_fn(input logic [1:0] t, input logic [11:0] cur,
                                           input logic [15:0] full, input logic [15:0] zero);
    int base;
    int span;
    int prod;
    base = 0;
    span = int'(`CAO_LOOP_TOP);
    if (cao_pkg::cao_in_t'(t) == cao_pkg::CAO_IN_4_20) begin
      base = int'(`CAO_LIVE_MIN);
      span = int'(`CAO_SPAN_LIVE);
    end
    prod = (int'($signed(full)) - int'($signed(zero))) * (int'(cur) - base);
    scale_fn = 16'(int'($signed(zero)) + prod / span);
  endfunction

  // Next alarm state; an out of range reading acts as beyond every threshold
  function automatic logic alarm_fn(input logic kind, input logic cur, input logic [15:0] v,
                                    input logic [15:0] thr, input logic [15:0] hys,
                                    input logic ovr, input logic und);
    int hi;
    int lo;
    int vs;
    hi = int'($signed(thr)) + int'($signed(hys));
    lo = int'($signed(thr)) - int'($signed(hys));
    vs = int'($signed(v));
    if (cao_pkg::cao_kind_t'(kind) == cao_pkg::CAO_AL_OVER) begin
      if (ovr) begin
        alarm_fn = 1'b1;
      end else if (und) begin
        alarm_fn = 1'b0;
      end else begin
        alarm_fn = cur ? (vs > lo) : (vs > hi);
      end
    end else begin
      if (und) begin
        alarm_fn = 1'b1;
      end else if (ovr) begin
        alarm_fn = 1'b0;
      end else begin
        alarm_fn = cur ? (vs < hi) : (vs < lo);
      end
    end
  endfunction

  function automatic logic [11:0] cur_fn(input logic [ACC_W-1:0] acc);
    cur_fn = acc[ACC_W-1 -: 12];
  endfunction

  always_comb begin
    int d;
    int k;
    logic [1:0] t;
    logic [11:0] cf;
    logic on;
    d  = 0;
    k  = 0;
    t  = 2'h0;
    cf = 12'h000;
    on = 1'b0;
    frac_next = fraction_digits_i;
    for (int c = 0; c < N; c++) begin
      t  = input_type_i[2*c +: 2];
      on = (t == cao_pkg::CAO_IN_0_20) || (t == cao_pkg::CAO_IN_4_20);
      // First order filter, shift set by level, clamped at the deepest
      k = int'(filter_level_i[3*c +: 3]);
      if (k > int'(`CAO_FILT_MAX)) begin
        k = int'(`CAO_FILT_MAX);
      end
      acc_next[c] = acc_reg[c];
      if (sample_i) begin
        d = int'({loop_current_i[12*c +: 12], `CAO_FILT_FRAC'(0)}) - int'(acc_reg[c]);
        acc_next[c] = ACC_W'(int'(acc_reg[c]) + (d >>> k));
      end
      cf = cur_fn(acc_reg[c]);
      // Margins widen the span; beyond them a flag is raised beside the scaled value
      over_next[c] = on && (int'(cf) > int'(`CAO_LOOP_TOP)
                     + int'(overrange_margin_i[8*c +: 8]));
      under_next[c] = on && (t == cao_pkg::CAO_IN_4_20) && (int'(cf) < int'(`CAO_LIVE_MIN)
                      - int'(underrange_margin_i[9*c +: 9]));
      val_next[16*c +: 16] = on ? scale_fn(t, cf, full_scale_reading_i[16*c +: 16],
                             zero_scale_reading_i[16*c +: 16]) : 16'h0000;
      // Thresholds are taken as given, never clipped to the channel span
      al1_next[c] = on && alarm_fn(first_alarm_kind_i[c], al1_reg[c], val_reg[16*c +: 16],
                    threshold1_i[16*c +: 16], hysteresis1_i[16*c +: 16],
                    over_reg[c], under_reg[c]);
      al2_next[c] = on && alarm_fn(second_alarm_kind_i[c], al2_reg[c], val_reg[16*c +: 16],
                    threshold2_i[16*c +: 16], hysteresis2_i[16*c +: 16],
                    over_reg[c], under_reg[c]);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int c = 0; c < N; c++) begin
        acc_reg[c] <= '0;
      end
      val_reg   <= '0;
      frac_reg  <= '0;
      over_reg  <= '0;
      under_reg <= '0;
      al1_reg   <= '0;
      al2_reg   <= '0;
    end else begin
      for (int c = 0; c < N; c++) begin
        acc_reg[c] <= acc_next[c];
      end
      val_reg   <= val_next;
      frac_reg  <= frac_next;
      over_reg  <= over_next;
      under_reg <= under_next;
      al1_reg   <= al1_next;
      al2_reg   <= al2_next;
    end
  end

  assign lnk.al1                 = al1_reg;
  assign lnk.al2                 = al2_reg;
  assign display_value_o         = val_reg;
  assign fraction_digits_o       = frac_reg;
  assign overrange_indication_o  = over_reg;
  assign underrange_indication_o = under_reg;
  assign alarm1_o                = al1_reg;
  assign alarm2_o                = al2_reg;
  assign relay_closed_o          = relay_w;

  // Delays and holds run on whole seconds from one shared tick
  cao_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .lnk      (lnk.tmr)
  );

  for (genvar m = 0; m < M; m++) begin : g_out
    cao_relay #(.N(N)) u_relay (
      .clk_i      (clk_i),
      .arst_n_i   (arst_n_i),
      .lnk        (lnk.relay),
      .mode_i     (out_mode_i[2*m +: 2]),
      .comb_i     (channel_combine_rule_i[m]),
      .src_i      (out_source_i[3*N*m +: 3*N]),
      .close_d_i  (close_delay_i[`CAO_TIME_W*m +: `CAO_TIME_W]),
      .open_d_i   (open_delay_i[`CAO_TIME_W*m +: `CAO_TIME_W]),
      .closed_h_i (closed_hold_i[`CAO_TIME_W*m +: `CAO_TIME_W]),
      .open_h_i   (open_hold_i[`CAO_TIME_W*m +: `CAO_TIME_W]),
      .closed_o   (relay_w[m])
    );
  end

  for (genvar c = 0; c < N; c++) begin : g_chk_ch
    // Shorthands for the checks of this channel
    logic        on_c;
    logic [1:0]  typ_c;
    logic [11:0] cf_c;
    int          v_c;
    int          t1_c;
    int          h1_c;
    int          t2_c;
    int          h2_c;
    assign typ_c = input_type_i[2*c +: 2];
    assign on_c  = (typ_c == 2'h1) || (typ_c == 2'h2);
    assign cf_c  = cur_fn(acc_reg[c]);
    assign v_c   = int'($signed(val_reg[16*c +: 16]));
    assign t1_c  = int'($signed(threshold1_i[16*c +: 16]));
    assign h1_c  = int'($signed(hysteresis1_i[16*c +: 16]));
    assign t2_c  = int'($signed(threshold2_i[16*c +: 16]));
    assign h2_c  = int'($signed(hysteresis2_i[16*c +: 16]));

    a_inactive_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (input_type_i[2*c +: 2] == 2'h0) |=> (val_reg[16*c +: 16] == 16'h0000
      && !over_reg[c] && !under_reg[c])) else $error("inactive channel not quiet");
    a_over_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (input_type_i[2*c +: 2] == 2'h1 && int'(cur_fn(acc_reg[c])) > int'(`CAO_LOOP_TOP)
      + int'(overrange_margin_i[8*c +: 8])) |=> over_reg[c]) else $error("over flag missed");
    a_under_mode: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (input_type_i[2*c +: 2] == 2'h1) |=> !under_reg[c])
      else $error("under flag outside 4-20 mode");
    a_zero_end: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (input_type_i[2*c +: 2] == 2'h1 && cur_fn(acc_reg[c]) == 12'h000)
      |=> (val_reg[16*c +: 16] == $past(zero_scale_reading_i[16*c +: 16])))
      else $error("bottom current not zero scale");
    a_filter_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (sample_i && filter_level_i[3*c +: 3] == 3'h0)
      |=> (cur_fn(acc_reg[c]) == $past(loop_current_i[12*c +: 12])))
      else $error("unfiltered level lags");
    a_alarm_rise: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (on_c && first_alarm_kind_i[c]
      && !al1_reg[c] && !under_reg[c]
      && v_c > t1_c + h1_c)
      |=> al1_reg[c])
      else $error("over alarm did not set");
    a_alarm_keep: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (on_c && first_alarm_kind_i[c]
      && al1_reg[c] && !under_reg[c]
      && v_c > t1_c - h1_c)
      |=> al1_reg[c])
      else $error("over alarm cleared early");
    a_high_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (on_c && first_alarm_kind_i[c] && al1_reg[c] && !over_reg[c] && !under_reg[c]
      && v_c <= t1_c - h1_c) |=> !al1_reg[c])
      else $error("over alarm stuck");
    a_low_rise: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (on_c && !second_alarm_kind_i[c] && !al2_reg[c] && !over_reg[c]
      && v_c < t2_c - h2_c) |=> al2_reg[c])
      else $error("under alarm did not set");
    a_low_keep: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (on_c && !second_alarm_kind_i[c] && al2_reg[c] && !over_reg[c]
      && v_c < t2_c + h2_c) |=> al2_reg[c])
      else $error("under alarm cleared early");
    a_low_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (on_c && !second_alarm_kind_i[c] && al2_reg[c] && !over_reg[c] && !under_reg[c]
      && v_c >= t2_c + h2_c) |=> !al2_reg[c])
      else $error("under alarm stuck");
    // Range flags override the thresholds in their own direction
    a_under_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (typ_c == 2'h2 && int'(cf_c) < int'(`CAO_LIVE_MIN) - int'(underrange_margin_i[9*c +: 9]))
      |=> under_reg[c]) else $error("under flag missed");
    a_live_over: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (typ_c == 2'h2 && int'(cf_c) > int'(`CAO_LOOP_TOP) + int'(overrange_margin_i[8*c +: 8]))
      |=> over_reg[c]) else $error("over flag missed");
    a_over_alarm: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (on_c && over_reg[c]) |=> (al1_reg[c] == $past(first_alarm_kind_i[c])))
      else $error("over range alarm wrong");
    a_under_alarm: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (on_c && under_reg[c]) |=> (al2_reg[c] == !$past(second_alarm_kind_i[c])))
      else $error("under range alarm wrong");
    a_off_alarms: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !on_c |=> (!al1_reg[c] && !al2_reg[c]))
      else $error("inactive channel alarms");
    a_frac_pass: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> (frac_reg[2*c +: 2] == $past(fraction_digits_i[2*c +: 2])))
      else $error("fraction digits not passed");
    a_filter_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !sample_i |=> (acc_reg[c] == $past(acc_reg[c])))
      else $error("filter moved without sample");
    a_full_end: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (typ_c == 2'h1 && cf_c == `CAO_LOOP_TOP)
      |=> (val_reg[16*c +: 16] == $past(full_scale_reading_i[16*c +: 16])))
      else $error("top current not full scale");
    a_live_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (typ_c == 2'h2 && cf_c == `CAO_LIVE_MIN)
      |=> (val_reg[16*c +: 16] == $past(zero_scale_reading_i[16*c +: 16])))
      else $error("live zero not zero scale");
    a_live_full: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (typ_c == 2'h2 && cf_c == `CAO_LOOP_TOP)
      |=> (val_reg[16*c +: 16] == $past(full_scale_reading_i[16*c +: 16])))
      else $error("live top not full scale");
  end
endmodule // cao_top

// ==== verilog/cao_params.svh ====
/*
 Constants for the channel alarm and output control block: loop current
 points, filter limits and the timing tick.
 Assumes currents arrive in 0.01 mA units and the clock runs at 100 MHz.
*/
`ifndef CAO_PARAMS_SVH
`define CAO_PARAMS_SVH

// Loop current points, 0.01 mA units
`define CAO_LOOP_TOP    12'h7D0
`define CAO_LIVE_MIN    12'h190
`define CAO_SPAN_LIVE   12'h640

// Filter: deepest level and fraction bits kept in the accumulator
`define CAO_FILT_MAX    3'h5
`define CAO_FILT_FRAC   5

// Timing tick: period in seconds, clock in Hz, derived cycle count
`define CAO_TICK_S      1
`define CAO_CLK_HZ      100000000
`define CAO_TICK_CYCLES (`CAO_TICK_S * `CAO_CLK_HZ)

// Width of every delay and hold setting, seconds
`define CAO_TIME_W      10

`endif

// ==== verilog/cao_pkg.sv ====
/*
 Types shared by the channel alarm and output control block.
 Assumes the configuration ports carry these codes in their natural order.
*/
package cao_pkg;
  typedef enum logic [1:0] {CAO_IN_OFF, CAO_IN_0_20, CAO_IN_4_20} cao_in_t;
  typedef enum logic {CAO_AL_UNDER, CAO_AL_OVER} cao_kind_t;
  typedef enum logic [1:0] {CAO_OUT_OFF, CAO_OUT_CLOSE_ACT, CAO_OUT_OPEN_ACT} cao_mode_t;
  typedef enum logic [2:0] {
    CAO_SRC_NONE, CAO_SRC_AL1, CAO_SRC_AL2, CAO_SRC_EITHER, CAO_SRC_BOTH
  } cao_src_t;
  typedef enum logic {CAO_COMB_OR, CAO_COMB_AND} cao_comb_t;
endpackage

// ==== verilog/cao_link_if.sv ====
/*
 Carries channel alarms and the one-second tick to the output controllers.
 Assumes a single clock domain; no handshake is needed.
*/
interface cao_link_if #(parameter int N = 4);
  logic [N-1:0] al1;
  logic [N-1:0] al2;
  logic         tick;
  modport chan  (output al1, output al2);
  modport tmr   (output tick);
  modport relay (input al1, input al2, input tick);
endinterface

// ==== verilog/cao_tick.sv ====
/*
 One-second timing tick, a single-cycle pulse.
 Assumes TICK_CYCLES is the clock count of one second.
*/
`include "cao_params.svh"
module cao_tick #(
  parameter int unsigned TICK_CYCLES = `CAO_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Tick out
  cao_link_if.tmr   lnk
);
  logic [31:0] cnt_reg, cnt_next;
  logic        tick_reg, tick_next;

  if (TICK_CYCLES < 1) begin : g_chk
    $error("cao_tick: TICK_CYCLES must be at least 1");
  end

  always_comb begin
    tick_next = (cnt_reg == 32'(TICK_CYCLES - 1));
    cnt_next  = tick_next ? 32'h0 : cnt_reg + 32'h1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg  <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign lnk.tick = tick_reg;
endmodule // cao_tick

// ==== verilog/cao_relay.sv ====
/*
 One output: channel combine, up-down delay counter, hold timer, polarity.
 Assumes alarms and the tick come in over the link interface.
*/
`include "cao_params.svh"
module cao_relay #(
  parameter int N = 4
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  // Alarms and tick
  cao_link_if.relay                  lnk,
  // Configuration
  input  wire logic [1:0]            mode_i,
  input  wire logic                  comb_i,
  input  wire logic [3*N-1:0]        src_i,
  input  wire logic [`CAO_TIME_W-1:0] close_d_i,
  input  wire logic [`CAO_TIME_W-1:0] open_d_i,
  input  wire logic [`CAO_TIME_W-1:0] closed_h_i,
  input  wire logic [`CAO_TIME_W-1:0] open_h_i,
  // Relay
  output logic                       closed_o
);
  logic                   act_reg, act_next, closed_reg, closed_next, func, live, cls;
  logic [`CAO_TIME_W-1:0] cnt_reg, cnt_next, hold_reg, hold_next;

  function automatic logic chan_hit(input logic [2:0] s, input logic a1, input logic a2);
    case (cao_pkg::cao_src_t'(s))
      cao_pkg::CAO_SRC_AL1:    chan_hit = a1;
      cao_pkg::CAO_SRC_AL2:    chan_hit = a2;
      cao_pkg::CAO_SRC_EITHER: chan_hit = a1 | a2;
      cao_pkg::CAO_SRC_BOTH:   chan_hit = a1 & a2;
      default:                 chan_hit = 1'b0;
    endcase
  endfunction

  always_comb begin
    logic any, all, att;
    any = 1'b0;
    all = 1'b1;
    att = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (src_i[3*i +: 3] != 3'h0) begin
        att = 1'b1;
        any = any | chan_hit(src_i[3*i +: 3], lnk.al1[i], lnk.al2[i]);
        all = all & chan_hit(src_i[3*i +: 3], lnk.al1[i], lnk.al2[i]);
      end
    end
    // Nothing attached never counts as all in alarm
    func = (comb_i == cao_pkg::CAO_COMB_AND) ? (att & all) : any;
    cls  = (mode_i == cao_pkg::CAO_OUT_CLOSE_ACT);
    live = cls || (mode_i == cao_pkg::CAO_OUT_OPEN_ACT);
    act_next  = act_reg;
    cnt_next  = cnt_reg;
    hold_next = hold_reg;
    if (!live) begin
      act_next  = 1'b0;
      cnt_next  = '0;
      hold_next = '0;
    end else if (lnk.tick) begin
      if (hold_reg != '0) begin
        hold_next = hold_reg - 1'b1;
      end else if (!act_reg) begin
        if (func && ({1'b0, cnt_reg} + 1'b1 >= {1'b0, close_d_i})) begin
          act_next  = 1'b1;
          cnt_next  = open_d_i;
          hold_next = cls ? closed_h_i : open_h_i;
        end else if (func) begin
          cnt_next = cnt_reg + 1'b1;
        end else if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end
      end else if (!func) begin
        if (cnt_reg <= `CAO_TIME_W'(1)) begin
          act_next  = 1'b0;
          cnt_next  = '0;
          hold_next = cls ? open_h_i : closed_h_i;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end else if (cnt_reg < open_d_i) begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
    closed_next = live & (cls ? act_next : ~act_next);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_reg    <= 1'b0;
      cnt_reg    <= '0;
      hold_reg   <= '0;
      closed_reg <= 1'b0;
    end else begin
      act_reg    <= act_next;
      cnt_reg    <= cnt_next;
      hold_reg   <= hold_next;
      closed_reg <= closed_next;
    end
  end

  assign closed_o = closed_reg;

  a_out_inactive: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (mode_i == 2'h0) |=> !closed_o) else $error("inactive output not open");
  a_out_polarity: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (mode_i == 2'h1) |=> (closed_o == act_reg)) else $error("relay polarity wrong");
  a_hold_freeze: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (live && lnk.tick && hold_reg != '0) |=> ($stable(act_reg) && $stable(cnt_reg)))
    else $error("state moved during hold");
  a_zero_close: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (live && lnk.tick && hold_reg == '0 && !act_reg && func && close_d_i == '0) |=> act_reg)
    else $error("zero delay did not switch");
  a_open_count: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (live && lnk.tick && hold_reg == '0 && act_reg && !func && cnt_reg > `CAO_TIME_W'(1))
    |=> (act_reg && cnt_reg == $past(cnt_reg) - 1'b1)) else $error("open count wrong");
endmodule // cao_relay

// ==== verification/cao_sensor.sv ====
/*
 Current-loop sensor bank model: presents every channel's loop current.
 Assumes the bench sets the levels in 0.01 mA units.
*/
module cao_sensor #(
  parameter int N = 4
) (
  // Clock and levels
  input  wire logic            clk_i,
  input  wire logic [12*N-1:0] level_i,
  // Toward the block
  output logic      [12*N-1:0] loop_current_o,
  output logic                 sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    loop_current_o = '0;
    sample_o       = 1'b0;
  end
  // Converter refreshes every cycle, off the sampling edge
  always @(negedge clk_i) begin
    loop_current_o <= level_i;
    sample_o       <= 1'b1;
  end
endmodule // cao_sensor

// ==== verification/cao_top_tb.sv ====
/*
 Self-checking bench: scaling, range flags, alarms and relay timing.
 Assumes the sensor model and a shortened tick of TK cycles.
*/
module cao_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N  = 4;
  localparam int M  = 2;
  localparam int TK = 10;
  logic            clk_i    = 1'b0;
  logic            arst_n_i = 1'b0;
  logic [12*N-1:0] level    = '0;
  logic [12*N-1:0] cur;
  logic            smp;
  logic [3:0]      omode    = 4'h9;
  logic [63:0]     dv;
  logic [7:0]      fdo;
  logic [3:0]      ovr;
  logic [3:0]      und;
  logic [3:0]      a1;
  logic [3:0]      a2;
  logic [7:0]      ityp     = 8'h06;
  logic [63:0]     fsr      = 64'h03E8;
  logic [63:0]     zsr      = {32'h0, 16'h03E8, 16'h0000};
  logic [11:0]     flt      = 12'h000;
  logic [31:0]     omg      = 32'h32;
  logic [35:0]     umg      = 36'h064;
  logic [3:0]      kind1    = 4'h1;
  logic [63:0]     thr1     = 64'h01F4;
  logic [63:0]     hys1     = 64'h000A;
  logic [1:0]      comb     = 2'h2;
  logic [23:0]     src      = 24'h001001;
  logic [19:0]     cdly     = 20'h00002;
  logic [19:0]     odly     = 20'h00001;
  logic [19:0]     ohld     = 20'h00003;
  logic [1:0]      rly;
  int              error_cnt = 0;
  int              checked   = 0;
  int              cyc       = 0;

  initial forever #5 clk_i = ~clk_i;

  cao_sensor #(.N(N)) cao_sensor_inst (.clk_i(clk_i), .level_i(level),
    .loop_current_o(cur), .sample_o(smp));

  // Out0 closes on active, delays 2/1, open hold 3; out1 opens on active, AND
  cao_top #(.N(N), .M(M), .TICK_CYCLES(TK)) cao_top_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .loop_current_i(cur), .sample_i(smp),
    .input_type_i(ityp), .full_scale_reading_i(fsr),
    .zero_scale_reading_i(zsr), .fraction_digits_i(8'h02),
    .filter_level_i(flt), .overrange_margin_i(omg),
    .underrange_margin_i(umg), .first_alarm_kind_i(kind1),
    .second_alarm_kind_i(4'h0), .threshold1_i(thr1),
    .threshold2_i({48'h0, 16'h0064}), .hysteresis1_i(hys1),
    .hysteresis2_i(64'h0), .out_mode_i(omode), .channel_combine_rule_i(comb),
    .out_source_i(src), .close_delay_i(cdly), .open_delay_i(odly),
    .closed_hold_i(20'h00000), .open_hold_i(ohld), .display_value_o(dv),
    .fraction_digits_o(fdo), .overrange_indication_o(ovr),
    .underrange_indication_o(und), .alarm1_o(a1), .alarm2_o(a2),
    .relay_closed_o(rly));

  task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_b(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // Relay only moves on a tick, so allow one tick period plus slack
  task automatic wait_r(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (rly[i] !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chk_b("relay_wait", v, rly[i]);
  endtask

  task automatic setlv(input logic [11:0] c0, input logic [11:0] c1);
    level = {24'h0, c1, c0};
    repeat (5) @(negedge clk_i);
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc >= 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    level = {24'h0, 12'h1F4, 12'h4B0};
    repeat (16) @(negedge clk_i);
    chk_b("relay1_rst", 1'b0, rly[1]);
    arst_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk_v("disp0", 16'h01F4, dv[15:0]);
    chk_v("disp1", 16'h02EE, dv[31:16]);
    chk_v("frac0", 16'h0002, {14'h0, fdo[1:0]});
    chk_b("al1_0", 1'b0, a1[0]);
    chk_b("relay1", 1'b1, rly[1]);
    setlv(12'h4D0, 12'h1F4);
    chk_b("al1_0", 1'b1, a1[0]);
    wait_r(1, 1'b0, TK + 2);
    chk_b("relay0", 1'b0, rly[0]);
    wait_r(0, 1'b1, TK + 2);
    setlv(12'h4B0, 12'h1F4);
    chk_b("al1_0", 1'b1, a1[0]);
    setlv(12'h490, 12'h1F4);
    chk_b("al1_0", 1'b0, a1[0]);
    wait_r(0, 1'b0, TK + 2);
    // Alarm back at once: open hold must keep the relay open
    setlv(12'h4D0, 12'h1F4);
    repeat (3 * TK - 8) @(negedge clk_i);
    chk_b("relay0_hold", 1'b0, rly[0]);
    wait_r(0, 1'b1, 2 * TK + 8);
    setlv(12'h803, 12'h000);
    chk_b("ovr0", 1'b1, ovr[0]);
    chk_b("al1_0", 1'b1, a1[0]);
    chk_b("und1", 1'b0, und[1]);
    setlv(12'h802, 12'h000);
    chk_b("ovr0", 1'b0, ovr[0]);
    setlv(12'h12B, 12'h000);
    chk_b("und0", 1'b1, und[0]);
    setlv(12'h12C, 12'h000);
    chk_b("und0", 1'b0, und[0]);
    chk_v("disp0_low", 16'hFFC2, dv[15:0]);
    chk_b("al2_0", 1'b1, a2[0]);
    // Deepest filter: five samples cannot reach a far step
    flt = 12'h005;
    setlv(12'h4B0, 12'h000);
    chk_b("filt_lag", 1'b1, dv[15:0] != 16'h01F4);
    omode = 4'h1;
    ityp  = 8'h04;
    repeat (2) @(negedge clk_i);
    chk_b("relay1_off", 1'b0, rly[1]);
    chk_v("disp0_off", 16'h0000, dv[15:0]);
    chk_b("al1_off", 1'b0, a1[0]);
    complete_run();
  end
endmodule // cao_top_tb
